// file: rsc_defines.svh
// Timing figures, reset values and vectors of the reset and start-up controller
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RSC_CLK_HZ      100000000
`define RSC_POWERUP_MS  64
`define RSC_POWERUP_CYC (`RSC_POWERUP_MS * (`RSC_CLK_HZ / 1000))
`define RSC_WDT_CYC     1600
`define RSC_FILT_CYC    4

// ------------------------------------------------------------
// Reset values and vectors
// ------------------------------------------------------------
`define RSC_FLAGS_POR   8'h1c
`define RSC_RESET_VEC   16'h0000
`define RSC_IRQ_VEC     16'h0004

`endif

// file: rsc_pkg.sv
// Types shared by the reset and start-up controller
package rsc_pkg;

    typedef struct packed {
        logic low_power_brownout_en_n;
        logic master_clear_enable_cfg;
        logic low_voltage_program_cfg;
        logic powerup_timer_enable_n;
        logic stack_fault_reset_enable;
        logic osc_start_required;
    } rsc_cfg_s;

    typedef struct packed {
        logic stack_overflow_flag;
        logic stack_underflow_flag;
        logic rsvd;
        logic watchdog_reset_flag_n;
        logic pin_reset_flag_n;
        logic soft_reset_flag_n;
        logic poweron_flag_n;
        logic brownout_reset_flag;
    } rsc_flags_s;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'h1,
        ST_START = 3'h2,
        ST_RUN   = 3'h4
    } rsc_state_e;

    typedef enum logic [1:0] {
        PC_ZERO = 2'h0,
        PC_NEXT = 2'h1,
        PC_VEC  = 2'h2
    } rsc_pc_e;

endpackage : rsc_pkg

// file: rsc_top.sv
// Reset source merging, start-up sequencing and reset cause flags
//
// Behaviour
// [R1] OR both brown-out requests into one
// [R2] Low supply holds reset, clears brown-out flag
// [R3] Active-low config bit enables low-power detector
// [R4] Pin function off only when both bits zero
// [R5] Pin held low keeps device in reset
// [R6] Short pin glitches are filtered out
// [R7] Disabled pin is input, software pull-up
// [R8] Watchdog expiry resets, updates timeout flags
// [R9] Reset instruction clears soft-reset flag only
// [R10] Enabled stack fault resets, sets its flag
// [R11] Programming exit behaves as power-on reset
// [R12] Power-up timer optional, active-low enable
// [R13] Start needs timer, oscillator, pin release
// [R14] Timers run independently of the pin
// [R15] Power-on loads 0000h, sets start flags
// [R16] Brown-out loads 0000h, clears brown-out flag
// [R17] Watchdog reset or wake updates flags
// [R18] Pin reset clears pin flag, sleep variant
// [R19] Interrupt wake runs PC+1, then vector if interrupts are globally enabled
// [R20] Power-up timer holds reset 64 ms
// [R21] Hardware clears flags, software sets them; the stack fault flags are set by hardware
// [R22] Reset released on one clock edge
`include "rsc_defines.svh"

module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned POWERUP_CYC = `RSC_POWERUP_CYC,
    parameter int unsigned WDT_CYC     = `RSC_WDT_CYC,
    parameter int unsigned FILT_CYC    = `RSC_FILT_CYC
)(
    // Clock and power-on reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Configuration word
    input  wire rsc_cfg_s   cfg,
    // Reset sources
    input  wire logic       low_power_brownout_detector,
    input  wire logic       main_brownout_req,
    input  wire logic       master_clear_pin,
    input  wire logic       prog_mode_exit,
    input  wire logic       reset_instr,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       stack_overflow,
    input  wire logic       stack_underflow,
    input  wire logic       osc_start_done,
    // Sleep and wake-up
    input  wire logic       sleeping,
    input  wire logic       irq_wake,
    input  wire logic       global_irq_enable,
    // Software access
    input  wire logic       sw_pullup_en,
    input  wire logic       flags_wr,
    input  wire rsc_flags_s flags_wdata,
    // Reset and flags
    output logic            device_reset,
    output logic            brownout_out,
    output rsc_flags_s      power_control_reg,
    output logic            timeout_flag_n,
    output logic            powerdown_flag_n,
    // Program counter control
    output logic            pc_load,
    output rsc_pc_e         pc_sel,
    output logic [15:0]     pc_target,
    output logic            ret_push,
    // Pin
    output logic            pin_pullup_en,
    output logic            pin_gpio_in
);

    // ------------------------------------------------------------
    // Widths and end counts
    // ------------------------------------------------------------
    localparam int PW = $clog2(POWERUP_CYC + 1);
    localparam int WW = $clog2(WDT_CYC + 1);
    localparam int FW = $clog2(FILT_CYC + 1);
    localparam logic [PW-1:0] PU_LAST = PW'(POWERUP_CYC - 1);
    localparam logic [WW-1:0] WD_LAST = WW'(WDT_CYC - 1);
    localparam logic [FW-1:0] FL_LAST = FW'(FILT_CYC - 1);

    rsc_state_e      state_r;
    rsc_state_e      state_nxt;
    logic            cold_r;
    logic [PW-1:0]   pu_cnt_r;
    logic [WW-1:0]   wd_cnt_r;
    logic [FW-1:0]   filt_cnt_r;
    logic            mc_low_r;
    logic            wake_pend_r;
    logic            reset_r;
    logic            brownout_r;
    rsc_flags_s      flags_r;
    rsc_flags_s      flags_nxt;
    logic            timeout_n_r;
    logic            timeout_n_nxt;
    logic            powerdown_n_r;
    logic            powerdown_n_nxt;
    logic            pc_load_r;
    rsc_pc_e         pc_sel_r;
    logic [15:0]     pc_target_r;
    logic            ret_push_r;
    logic            pullup_r;
    logic            gpio_r;

    logic brownout_req;
    logic mc_en;
    logic mc_hold;
    logic run;
    logic cold_ev;
    logic wd_to;
    logic wd_reset;
    logic stk_ovf;
    logic stk_unf;
    logic warm_ev;
    logic wake_wd;
    logic wake_irq;
    logic pu_done;
    logic ost_ok;
    logic start_ok;

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    assign brownout_req = (~cfg.low_power_brownout_en_n & low_power_brownout_detector)
                        | main_brownout_req; // [R1] [R3]
    assign mc_en   = cfg.master_clear_enable_cfg | cfg.low_voltage_program_cfg; // [R4]
    assign mc_hold = mc_en & mc_low_r; // [R5]
    assign run     = (state_r == ST_RUN);
    assign cold_ev = brownout_req | prog_mode_exit; // [R2] [R11]
    assign wd_to   = run & (wd_cnt_r == WD_LAST);
    assign wd_reset = wd_to & ~sleeping; // [R8]
    assign stk_ovf = run & cfg.stack_fault_reset_enable & stack_overflow; // [R10]
    assign stk_unf = run & cfg.stack_fault_reset_enable & stack_underflow; // [R10]
    assign warm_ev = run & (wd_reset | reset_instr | stk_ovf | stk_unf | mc_hold);
    assign wake_wd  = wd_to & sleeping; // [R17]
    assign wake_irq = run & sleeping & irq_wake & ~mc_hold & ~wd_to;

    // Pin low must persist before it counts as a reset
    always_ff @(posedge core_clk)
    begin
        if (srst || master_clear_pin)
        begin
            filt_cnt_r <= '0;
            mc_low_r   <= 1'b0;
        end
        else if (filt_cnt_r == FL_LAST)
        begin
            mc_low_r <= 1'b1; // [R6]
        end
        else
        begin
            filt_cnt_r <= filt_cnt_r + 1'b1;
        end
    end

    // Watchdog period, restarted by the clear instruction
    always_ff @(posedge core_clk)
    begin
        if (srst || reset_r || watchdog_clear_instr || wd_to)
        begin
            wd_cnt_r <= '0;
        end
        else
        begin
            wd_cnt_r <= wd_cnt_r + 1'b1; // [R8]
        end
    end

    // ------------------------------------------------------------
    // Start-up sequence
    // ------------------------------------------------------------
    assign pu_done  = cfg.powerup_timer_enable_n | ~cold_r
                    | (pu_cnt_r == PU_LAST); // [R12] [R20]
    assign ost_ok   = ~cold_r | ~cfg.osc_start_required | osc_start_done;
    assign start_ok = pu_done & ost_ok & ~mc_hold; // [R13]

    always_comb
    begin
        state_nxt = state_r;
        if (cold_ev)
        begin
            state_nxt = ST_HOLD; // [R2] [R11]
        end
        else
        begin
            case (state_r)
                ST_HOLD:
                    state_nxt = ST_START;
                ST_START:
                    if (start_ok)
                    begin
                        state_nxt = ST_RUN;
                    end
                ST_RUN:
                    if (warm_ev)
                    begin
                        state_nxt = ST_START;
                    end
                default:
                    state_nxt = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_r <= ST_HOLD;
            cold_r  <= 1'b1;
            reset_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            reset_r <= (state_nxt != ST_RUN); // [R22]
            if (cold_ev)
            begin
                cold_r <= 1'b1;
            end
            else if (warm_ev)
            begin
                cold_r <= 1'b0;
            end
        end
    end

    // Timer counts whatever the pin does
    always_ff @(posedge core_clk)
    begin
        if (srst || state_r == ST_HOLD)
        begin
            pu_cnt_r <= '0;
        end
        else if (state_r == ST_START && pu_cnt_r != PU_LAST)
        begin
            pu_cnt_r <= pu_cnt_r + 1'b1; // [R14] [R20]
        end
    end

    // ------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------
    // Hardware events are applied after a software write, so they win
    always_comb
    begin
        flags_nxt       = flags_wr ? flags_wdata : flags_r; // [R21]
        timeout_n_nxt   = timeout_n_r;
        powerdown_n_nxt = powerdown_n_r;
        if (prog_mode_exit)
        begin
            flags_nxt       = `RSC_FLAGS_POR; // [R11] [R15]
            timeout_n_nxt   = 1'b1;
            powerdown_n_nxt = 1'b1;
        end
        else if (brownout_req)
        begin
            flags_nxt.stack_overflow_flag  = 1'b0; // [R16]
            flags_nxt.stack_underflow_flag = 1'b0;
            flags_nxt.pin_reset_flag_n     = 1'b1;
            flags_nxt.soft_reset_flag_n    = 1'b1;
            flags_nxt.brownout_reset_flag  = 1'b0; // [R2] [R21]
            timeout_n_nxt   = 1'b1;
            powerdown_n_nxt = 1'b1;
        end
        else
        begin
            if (wd_reset)
            begin
                flags_nxt.watchdog_reset_flag_n = 1'b0; // [R8] [R17]
                timeout_n_nxt = 1'b0;
            end
            if (wake_wd)
            begin
                timeout_n_nxt   = 1'b0; // [R17]
                powerdown_n_nxt = 1'b0;
            end
            if (run && mc_hold)
            begin
                flags_nxt.pin_reset_flag_n = 1'b0; // [R18]
                if (sleeping)
                begin
                    timeout_n_nxt   = 1'b1;
                    powerdown_n_nxt = 1'b0;
                end
            end
            if (run && reset_instr)
            begin
                flags_nxt.soft_reset_flag_n = 1'b0; // [R9]
            end
            if (stk_ovf)
            begin
                flags_nxt.stack_overflow_flag = 1'b1; // [R10]
            end
            if (stk_unf)
            begin
                flags_nxt.stack_underflow_flag = 1'b1; // [R10]
            end
            if (wake_irq)
            begin
                timeout_n_nxt   = 1'b1; // [R19]
                powerdown_n_nxt = 1'b0;
            end
        end
        flags_nxt.rsvd = 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flags_r       <= `RSC_FLAGS_POR; // [R15]
            timeout_n_r   <= 1'b1;
            powerdown_n_r <= 1'b1;
            brownout_r    <= 1'b0;
        end
        else
        begin
            flags_r       <= flags_nxt;
            timeout_n_r   <= timeout_n_nxt;
            powerdown_n_r <= powerdown_n_nxt;
            brownout_r    <= brownout_req; // [R1]
        end
    end

    // ------------------------------------------------------------
    // Program counter control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pc_load_r   <= 1'b0;
            pc_sel_r    <= PC_ZERO;
            pc_target_r <= `RSC_RESET_VEC;
            ret_push_r  <= 1'b0;
            wake_pend_r <= 1'b0;
        end
        else
        begin
            pc_load_r  <= 1'b0;
            ret_push_r <= 1'b0;
            if (state_r == ST_START && state_nxt == ST_RUN)
            begin
                pc_load_r   <= 1'b1; // [R15] [R16] [R18]
                pc_sel_r    <= PC_ZERO;
                pc_target_r <= `RSC_RESET_VEC;
                wake_pend_r <= 1'b0;
            end
            else if (run && !cold_ev && (wake_wd || wake_irq))
            begin
                pc_load_r   <= 1'b1; // [R17] [R19]
                pc_sel_r    <= PC_NEXT;
                wake_pend_r <= wake_irq & global_irq_enable;
            end
            else if (wake_pend_r)
            begin
                pc_load_r   <= 1'b1; // [R19]
                pc_sel_r    <= PC_VEC;
                pc_target_r <= `RSC_IRQ_VEC;
                ret_push_r  <= 1'b1;
                wake_pend_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin pull-up and input
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pullup_r <= 1'b1;
            gpio_r   <= 1'b0;
        end
        else
        begin
            pullup_r <= mc_en | sw_pullup_en; // [R5] [R7]
            gpio_r   <= ~mc_en & master_clear_pin; // [R7]
        end
    end

    assign device_reset      = reset_r;
    assign brownout_out      = brownout_r;
    assign power_control_reg = flags_r;
    assign timeout_flag_n    = timeout_n_r;
    assign powerdown_flag_n  = powerdown_n_r;
    assign pc_load           = pc_load_r;
    assign pc_sel            = pc_sel_r;
    assign pc_target         = pc_target_r;
    assign ret_push          = ret_push_r;
    assign pin_pullup_en     = pullup_r;
    assign pin_gpio_in       = gpio_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_bor_or;
        @(posedge core_clk) disable iff (srst)
        (low_power_brownout_detector && !cfg.low_power_brownout_en_n) |=> brownout_out;
    endproperty
    a_bor_or: assert property (p_bor_or) else $error("detector request lost"); // [R1]

    property p_lp_off;
        @(posedge core_clk) disable iff (srst)
        (cfg.low_power_brownout_en_n && !main_brownout_req) |=> !brownout_out;
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("disabled detector acted"); // [R3]

    property p_bor_hold;
        @(posedge core_clk) disable iff (srst)
        brownout_req |=> device_reset && !power_control_reg.brownout_reset_flag
                         && !power_control_reg.stack_overflow_flag;
    endproperty
    a_bor_hold: assert property (p_bor_hold) else $error("brown-out not held"); // [R2]

    property p_pin_off;
        @(posedge core_clk) disable iff (srst)
        (!cfg.master_clear_enable_cfg && !cfg.low_voltage_program_cfg)
            |=> pin_pullup_en == $past(sw_pullup_en) && pin_gpio_in == $past(master_clear_pin);
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin not general input"); // [R4]

    property p_glitch;
        @(posedge core_clk) disable iff (srst)
        $rose(mc_low_r) |-> !$past(master_clear_pin, 1) && !$past(master_clear_pin, 2);
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse accepted"); // [R6]

    property p_pin_rst;
        @(posedge core_clk) disable iff (srst)
        (run && mc_hold && !cold_ev) |=> device_reset && !power_control_reg.pin_reset_flag_n;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed"); // [R5]

    property p_wdt;
        @(posedge core_clk) disable iff (srst)
        (wd_reset && !cold_ev) |=> device_reset && !timeout_flag_n
                                   && !power_control_reg.watchdog_reset_flag_n;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset flags wrong"); // [R8]

    property p_soft;
        @(posedge core_clk) disable iff (srst)
        (run && reset_instr && !cold_ev && !flags_wr)
            |=> device_reset && !power_control_reg.soft_reset_flag_n
                && power_control_reg.poweron_flag_n == $past(flags_r.poweron_flag_n);
    endproperty
    a_soft: assert property (p_soft) else $error("reset instruction flags wrong"); // [R9]

    property p_stack;
        @(posedge core_clk) disable iff (srst)
        (stk_ovf && !cold_ev) |=> device_reset && power_control_reg.stack_overflow_flag;
    endproperty
    a_stack: assert property (p_stack) else $error("stack fault missed"); // [R10]

    property p_prog;
        @(posedge core_clk) disable iff (srst)
        prog_mode_exit |=> device_reset && power_control_reg == `RSC_FLAGS_POR
                           && timeout_flag_n && powerdown_flag_n;
    endproperty
    a_prog: assert property (p_prog) else $error("programming exit not cold"); // [R11]

    property p_start;
        @(posedge core_clk) disable iff (srst)
        $fell(device_reset) |-> $past(!mc_hold && ost_ok) && pc_load
                                && pc_sel == PC_ZERO && pc_target == `RSC_RESET_VEC;
    endproperty
    a_start: assert property (p_start) else $error("start before conditions"); // [R13]

    property p_pu_len;
        @(posedge core_clk) disable iff (srst)
        ($fell(device_reset) && $past(cold_r) && !$past(cfg.powerup_timer_enable_n))
            |-> $past(pu_cnt_r) == PU_LAST;
    endproperty
    a_pu_len: assert property (p_pu_len) else $error("power-up delay short"); // [R20]

    property p_irq_wake;
        @(posedge core_clk) disable iff (srst)
        (wake_irq && global_irq_enable && !cold_ev && !warm_ev)
            |=> pc_load && pc_sel == PC_NEXT && !powerdown_flag_n
            ##1 pc_load && ret_push && pc_target == `RSC_IRQ_VEC;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake order wrong"); // [R19]

endmodule : rsc_top

// file: rsc_far_model.sv
// Far-side model: reset pin with weak pull-up, and the sleeping core
module rsc_far_model (
    // Clock
    input  wire logic core_clk,
    // Bench commands
    input  wire logic pin_low,
    input  wire logic sleep_req,
    // Device side
    input  wire logic pin_pullup_en,
    input  wire logic pc_load,
    output logic      master_clear_pin,
    output logic      sleeping
);
    timeunit 1ns;
    timeprecision 1ps;

    logic float_r = 1'b0;
    logic slp_r   = 1'b0;

    always @(posedge core_clk)
        float_r <= ~float_r;
    // Held low by the outside party, else pull-up, else floating
    assign master_clear_pin = pin_low ? 1'b0 : (pin_pullup_en | float_r);
    // Core leaves sleep once a wake-up load is seen
    always @(posedge core_clk)
        slp_r <= pc_load ? 1'b0 : (slp_r | sleep_req);
    assign sleeping = slp_r;
endmodule : rsc_far_model

// file: rsc_top_tb.sv
// Self-checking bench of the reset and start-up controller
module rsc_top_tb
    import rsc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PWR  = 20;
    localparam int WDT  = 50;
    localparam int FILT = 4;

    logic       core_clk = 1'b0, srst = 1'b1, kick = 1'b1;
    rsc_cfg_s   cfg = 6'h13;
    logic       low_power_brownout_detector = 1'b0, main_brownout_req = 1'b0;
    logic       prog_mode_exit = 1'b0, reset_instr = 1'b0, watchdog_clear_instr = 1'b0;
    logic       stack_overflow = 1'b0, stack_underflow = 1'b0, osc_start_done = 1'b0;
    logic       irq_wake = 1'b0, global_irq_enable = 1'b0, sw_pullup_en = 1'b1;
    logic       flags_wr = 1'b0, pin_low = 1'b0, sleep_req = 1'b0;
    rsc_flags_s flags_wdata = 8'h00, power_control_reg;
    logic       device_reset, brownout_out, timeout_flag_n, powerdown_flag_n;
    logic       pc_load, ret_push, pin_pullup_en, pin_gpio_in, master_clear_pin, sleeping;
    rsc_pc_e    pc_sel;
    logic [15:0] pc_target;
    int         n_fail = 0, checked = 0, cyc = 0, n;

    rsc_top #(.POWERUP_CYC(PWR), .WDT_CYC(WDT), .FILT_CYC(FILT)) dut (
        .core_clk, .srst, .cfg, .low_power_brownout_detector, .main_brownout_req,
        .master_clear_pin, .prog_mode_exit, .reset_instr, .watchdog_clear_instr,
        .stack_overflow, .stack_underflow, .osc_start_done, .sleeping, .irq_wake,
        .global_irq_enable, .sw_pullup_en, .flags_wr, .flags_wdata, .device_reset,
        .brownout_out, .power_control_reg, .timeout_flag_n, .powerdown_flag_n,
        .pc_load, .pc_sel, .pc_target, .ret_push, .pin_pullup_en, .pin_gpio_in
    );

    rsc_far_model far (
        .core_clk, .pin_low, .sleep_req, .pin_pullup_en, .pc_load,
        .master_clear_pin, .sleeping
    );

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    // Cycle ceiling, and periodic watchdog clears while kick is set
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    always @(negedge core_clk)
        watchdog_clear_instr <= kick && (cyc[3:0] == 4'h0);

    // ----
    // Tasks
    // ----
    task automatic step(input int k);
        repeat (k) @(negedge core_clk);
    endtask : step

    task automatic ck1(input logic g, input logic e);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : ck1

    task automatic ckf(input rsc_flags_s e);
        checked++;
        if (power_control_reg !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, power_control_reg, e);
        end
    endtask : ckf

    task automatic wr(input rsc_flags_s v);
        flags_wdata = v;
        flags_wr = 1'b1;
        step(1);
        flags_wr = 1'b0;
    endtask : wr

    // One-cycle request: 0 reset instr, 1 overflow, 2 underflow, 3 prog exit
    task automatic pulse(input int k);
        {prog_mode_exit, stack_underflow, stack_overflow, reset_instr} = 4'(1 << k);
        step(1);
        {prog_mode_exit, stack_underflow, stack_overflow, reset_instr} = 4'h0;
    endtask : pulse

    task automatic nap();
        sleep_req = 1'b1;
        step(1);
        sleep_req = 1'b0;
    endtask : nap

    // Wait for reset to reach v; a release must come with the zero load
    task automatic wait_for(input logic v, output int c);
        for (c = 0; c < 300 && device_reset !== v; c++)
            step(1);
        if (v == 1'b0)
            ck1(pc_load && pc_sel === PC_ZERO && pc_target === 16'h0000, 1'b1);
    endtask : wait_for

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic print_verdict();
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // ----
    // Tests
    // ----
    initial
    begin
        step(2);
        srst = 1'b0;
        ckf(8'h1c);
        ck1(timeout_flag_n & powerdown_flag_n & device_reset, 1'b1);
        step(40);
        ck1(device_reset, 1'b1);
        osc_start_done = 1'b1;
        wait_for(1'b0, n);
        ck1(n < 4, 1'b1);
        wr(8'hff);
        ckf(8'hdf);
        pulse(3);
        ckf(8'h1c);
        wait_for(1'b0, n);
        ck1(n >= PWR && n <= PWR + 2, 1'b1);
        cfg.powerup_timer_enable_n = 1'b1;
        pulse(3);
        wait_for(1'b0, n);
        ck1(n < 4, 1'b1);
        cfg.powerup_timer_enable_n = 1'b0;
        pin_low = 1'b1;
        pulse(3);
        step(30);
        ck1(device_reset, 1'b1);
        pin_low = 1'b0;
        wait_for(1'b0, n);
        ck1(n < 4, 1'b1);
        done("start-up");
        wr(8'h1f);
        for (int k = 0; k < 3; k++)
        begin
            pulse(k);
            ck1(device_reset, 1'b1);
            ckf(k == 0 ? 8'h1b : (k == 1 ? 8'h9b : 8'hdb));
            wait_for(1'b0, n);
        end
        cfg.stack_fault_reset_enable = 1'b0;
        wr(8'h1f);
        pulse(1);
        step(1);
        ck1(device_reset, 1'b0);
        cfg.stack_fault_reset_enable = 1'b1;
        done("warm resets");
        pin_low = 1'b1;
        step(FILT - 1);
        pin_low = 1'b0;
        step(3);
        ck1(device_reset, 1'b0);
        for (int i = 3; i >= 0; i--)
        begin
            {cfg.master_clear_enable_cfg, cfg.low_voltage_program_cfg} = 2'(i);
            pin_low = 1'b1;
            step(FILT + 4);
            ck1(device_reset, i != 0);
            if (i == 3)
                ckf(8'h17);
            pin_low = 1'b0;
            if (i != 0)
                wait_for(1'b0, n);
        end
        step(2);
        ck1(pin_gpio_in, 1'b1);
        sw_pullup_en = 1'b0;
        step(2);
        ck1(pin_pullup_en, 1'b0);
        sw_pullup_en = 1'b1;
        cfg.master_clear_enable_cfg = 1'b1;
        done("reset pin");
        kick = 1'b0;
        wait_for(1'b1, n);
        ck1(n > WDT - 18 && n < WDT + 2, 1'b1);
        ckf(8'h07);
        ck1(timeout_flag_n, 1'b0);
        kick = 1'b1;
        wait_for(1'b0, n);
        for (int j = 0; j < 2; j++)
        begin
            wr(8'hff);
            {main_brownout_req, low_power_brownout_detector} = (j != 0) ? 2'b01 : 2'b10;
            step(3);
            ck1(device_reset & brownout_out, 1'b1);
            ckf(8'h1e);
            ck1(timeout_flag_n & powerdown_flag_n, 1'b1);
            {main_brownout_req, low_power_brownout_detector} = 2'b00;
            wait_for(1'b0, n);
        end
        cfg.low_power_brownout_en_n = 1'b1;
        low_power_brownout_detector = 1'b1;
        step(4);
        ck1(device_reset | brownout_out, 1'b0);
        low_power_brownout_detector = 1'b0;
        done("watchdog and brown-out");
        global_irq_enable = 1'b1;
        nap();
        irq_wake = 1'b1;
        step(1);
        irq_wake = 1'b0;
        ck1(pc_load && pc_sel === PC_NEXT, 1'b1);
        ck1(timeout_flag_n && !powerdown_flag_n, 1'b1);
        step(1);
        ck1(pc_load && ret_push && pc_sel === PC_VEC && pc_target === 16'h0004, 1'b1);
        step(2);
        kick = 1'b0;
        nap();
        for (n = 0; n < 80 && pc_load !== 1'b1; n++)
            step(1);
        ck1(pc_sel === PC_NEXT && !device_reset, 1'b1);
        ck1(timeout_flag_n | powerdown_flag_n, 1'b0);
        kick = 1'b1;
        step(2);
        wr(8'hff);
        nap();
        pin_low = 1'b1;
        step(FILT + 4);
        ckf(8'hd7);
        ck1(timeout_flag_n && !powerdown_flag_n, 1'b1);
        pin_low = 1'b0;
        wait_for(1'b0, n);
        done("sleep");
        print_verdict();
    end
endmodule : rsc_top_tb
